/* File: inc/dbgtc_pkg.sv */
// Functional notes
// - CPU writes to host_reset_trigger are ignored; only host writes act.
// - Reads of host_reset_trigger always return 0x00.
// - Host writing one to bit 0 requests a full microcontroller reset.
// - Comparator bytes reset to zero, readable; armed writes dropped.
// - Comparator A, B, FIFO word as byte pairs plus control register.
// - FIFO high byte is read-only and reads zero in event-only modes.
// - Reading FIFO high byte does not move the FIFO.
// - Reading FIFO low byte advances the FIFO; writes have no effect.
// - Event-only modes store bytes in low half, read out by low reads.
// - While armed, low-byte reads do not advance the FIFO.
// - Unarmed low-byte read stores last opcode address in last location.
// - Unarmed profiling returns the address stored eight reads earlier.
// - Control register readable and writable always, resets to zero.
// - Bit 7 enables the unit; cannot be set while secured.
// - Bit 6 arms a run; run end clears it; writing zero stops.
// - Bit 5 selects tag (1) or force (0) break; needs break enable.
// - Bit 4 lets triggers request CPU breaks; else they only store.
// - End trace breaks on trigger; begin trace breaks when FIFO fills.
// - Break timing is the same with or without trigger qualification.
// - Bit 2 gates comparator A on direction; bit 3 one read, zero write.
// - Bit 0 gates comparator B on direction; bit 1 one read, zero write.
// - Armed flag mirrors enabled arm bit; run ends on full or trigger.
// - Trigger codes 0011 and 0100 are event-only modes that store bytes.
package dbgtc_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int TRACE_DEPTH = 8;
  localparam int STAGE_DEPTH = 4;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [3:0] OFS_CMP_A_HI = 4'h0;
  localparam logic [3:0] OFS_CMP_A_LO = 4'h1;
  localparam logic [3:0] OFS_CMP_B_HI = 4'h2;
  localparam logic [3:0] OFS_CMP_B_LO = 4'h3;
  localparam logic [3:0] OFS_FIFO_HI = 4'h4;
  localparam logic [3:0] OFS_FIFO_LO = 4'h5;
  localparam logic [3:0] OFS_CONTROL = 4'h6;
  localparam logic [3:0] OFS_HOST_RESET = 4'h7;

  // ****************************************
  // Control fields and reset values
  // ****************************************
  localparam int CTL_UNIT_ENABLE = 7;
  localparam int CTL_ARM = 6;
  localparam int CTL_TAG = 5;
  localparam int CTL_BREAK_ENABLE = 4;
  localparam int CTL_DIR_A = 3;
  localparam int CTL_CHK_A = 2;
  localparam int CTL_DIR_B = 1;
  localparam int CTL_CHK_B = 0;
  localparam int HOST_FORCED_RESET_BIT = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ****************************************
  // Trigger mode codes
  // ****************************************
  localparam logic [3:0] TRG_A_ONLY = 4'h0;
  localparam logic [3:0] TRG_A_OR_B = 4'h1;
  localparam logic [3:0] TRG_A_THEN_B = 4'h2;
  localparam logic [3:0] TRG_EVENT_B = 4'h3;
  localparam logic [3:0] TRG_A_THEN_EVENT_B = 4'h4;
  localparam logic [3:0] TRG_INSIDE = 4'h7;
  localparam logic [3:0] TRG_OUTSIDE = 4'h8;

  typedef enum logic [1:0] {RUN_IDLE, RUN_SEEK, RUN_FILL} dbgtc_run_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic from_host;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dbgtc_reg_req_t;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic [15:0] addr;
    logic [7:0] data;
    logic op_fetch;
    logic op_exec;
  } dbgtc_cpu_bus_t;

endpackage : dbgtc_pkg

/* File: src/dbgtc_unit.sv */
`timescale 1ns/1ps

// ****************************************
// Staging FIFO
// ****************************************
module dbgtc_stage_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } dbgtc_fifo_state_t;

  dbgtc_fifo_state_t s_reg;
  dbgtc_fifo_state_t s_next;
  logic push;
  logic pop;

  assign in_ready = (s_reg.cnt != (PW+1)'(DEPTH));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data = s_reg.mem[s_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = (s_reg.wp == PW'(DEPTH-1)) ? '0 : PW'(s_reg.wp + 1'b1);
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == PW'(DEPTH-1)) ? '0 : PW'(s_reg.rp + 1'b1);
    end
    if (push && !pop) begin
      s_next.cnt = (PW+1)'(s_reg.cnt + 1'b1);
    end else if (pop && !push) begin
      s_next.cnt = (PW+1)'(s_reg.cnt - 1'b1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : dbgtc_stage_fifo

// ****************************************
// Debug trace and compare unit
// ****************************************
module dbgtc_unit
  import dbgtc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port, CPU and background host
  input wire dbgtc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Watched CPU bus
  input wire dbgtc_cpu_bus_t cpu_bus,
  // Trigger setup and security
  input wire logic [3:0] trig_mode,
  input wire logic trig_begin,
  input wire logic trigger_qualify,
  input wire logic mcu_secure,
  // Results
  output logic break_req,
  output logic break_tag,
  output logic mcu_reset_req,
  output logic run_active_flag,
  output logic [3:0] trace_count,
  output logic stage_full
);

  typedef struct packed {
    logic [7:0] ctl;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [TRACE_DEPTH-1:0][15:0] words;
    logic [3:0] cnt;
    logic [15:0] last_op;
    dbgtc_run_t phase;
    logic a_seen;
    logic [7:0] rdata;
    logic brk;
    logic brk_tag;
    logic rst_pulse;
  } dbgtc_state_t;

  dbgtc_state_t s_reg;
  dbgtc_state_t s_next;

  logic armed;
  logic event_mode;
  logic begin_mode;
  logic match_a;
  logic match_b;
  logic hit_a;
  logic hit_b;
  logic trig;
  logic cap_valid;
  logic [15:0] cap_word;
  logic st_in_ready;
  logic st_out_valid;
  logic st_out_ready;
  logic [15:0] st_out_data;
  logic trace_full;

  assign armed = s_reg.ctl[CTL_ARM] && s_reg.ctl[CTL_UNIT_ENABLE];
  assign event_mode = (trig_mode == TRG_EVENT_B) ||
                      (trig_mode == TRG_A_THEN_EVENT_B);
  assign begin_mode = trig_begin || event_mode;
  assign trace_full = (s_reg.cnt == 4'(TRACE_DEPTH));

  // ****************************************
  // Comparators
  // ****************************************
  always_comb begin
    match_a = cpu_bus.valid && (cpu_bus.addr == s_reg.cmp_a) &&
              (!s_reg.ctl[CTL_CHK_A] ||
               (cpu_bus.is_read == s_reg.ctl[CTL_DIR_A]));
    match_b = cpu_bus.valid && (cpu_bus.addr == s_reg.cmp_b) &&
              (!s_reg.ctl[CTL_CHK_B] ||
               (cpu_bus.is_read == s_reg.ctl[CTL_DIR_B]));
    // Tag qualification gates matches, not the break latency
    hit_a = match_a && (!trigger_qualify || cpu_bus.op_exec);
    hit_b = match_b && (!trigger_qualify || cpu_bus.op_exec);
    case (trig_mode)
      TRG_A_ONLY: trig = hit_a;
      TRG_A_OR_B: trig = hit_a || hit_b;
      TRG_A_THEN_B: trig = s_reg.a_seen && hit_b;
      TRG_EVENT_B: trig = hit_b;
      TRG_A_THEN_EVENT_B: trig = s_reg.a_seen && hit_b;
      TRG_INSIDE: trig = cpu_bus.valid && (cpu_bus.addr >= s_reg.cmp_a) &&
                         (cpu_bus.addr <= s_reg.cmp_b);
      TRG_OUTSIDE: trig = cpu_bus.valid && ((cpu_bus.addr < s_reg.cmp_a) ||
                          (cpu_bus.addr > s_reg.cmp_b));
      default: trig = 1'b0;
    endcase
  end

  // ****************************************
  // Capture into staging FIFO
  // ****************************************
  always_comb begin
    cap_valid = 1'b0;
    cap_word = WORD_ZERO;
    if (armed) begin
      if (event_mode) begin
        cap_valid = trig;
        cap_word = {BYTE_ZERO, cpu_bus.data};
      end else if ((s_reg.phase == RUN_FILL) ||
                   (s_reg.phase == RUN_SEEK && !begin_mode)) begin
        cap_valid = cpu_bus.valid && cpu_bus.op_fetch;
        cap_word = cpu_bus.addr;
      end
    end
  end

  // Draining stalls only while armed in begin mode with the trace store full; a begin run disarms as it fills
  assign st_out_ready = !(begin_mode && trace_full && armed);

  dbgtc_stage_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(cap_valid),
    .in_ready(st_in_ready),
    .in_data(cap_word),
    .out_valid(st_out_valid),
    .out_ready(st_out_ready),
    .out_data(st_out_data)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0] w;
    logic start;
    logic stop_run;
    w = reg_req.wdata;
    start = 1'b0;
    stop_run = 1'b0;
    s_next = s_reg;
    s_next.brk = 1'b0;
    s_next.rst_pulse = 1'b0;
    if (cpu_bus.valid && cpu_bus.op_fetch) begin
      s_next.last_op = cpu_bus.addr;
    end
    // Read data and read side effects
    if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_CMP_A_HI: s_next.rdata = s_reg.cmp_a[15:8];
        OFS_CMP_A_LO: s_next.rdata = s_reg.cmp_a[7:0];
        OFS_CMP_B_HI: s_next.rdata = s_reg.cmp_b[15:8];
        OFS_CMP_B_LO: s_next.rdata = s_reg.cmp_b[7:0];
        OFS_FIFO_HI: s_next.rdata = event_mode ? BYTE_ZERO :
                                    s_reg.words[0][15:8];
        OFS_FIFO_LO: s_next.rdata = s_reg.words[0][7:0];
        OFS_CONTROL: s_next.rdata = s_reg.ctl;
        OFS_HOST_RESET: s_next.rdata = BYTE_ZERO;
        default: s_next.rdata = BYTE_ZERO;
      endcase
      if (reg_req.addr == OFS_FIFO_LO && !armed) begin
        for (int i = 0; i < TRACE_DEPTH - 1; i++) begin
          s_next.words[i] = s_reg.words[i+1];
        end
        s_next.words[TRACE_DEPTH-1] = s_reg.last_op;
      end
    end
    // Staged words enter the trace store at its tail
    if (st_out_valid && st_out_ready) begin
      for (int i = 0; i < TRACE_DEPTH - 1; i++) begin
        s_next.words[i] = s_next.words[i+1];
      end
      s_next.words[TRACE_DEPTH-1] = st_out_data;
      if (armed && !trace_full) begin
        s_next.cnt = 4'(s_reg.cnt + 1'b1);
      end
    end
    // Run sequencing
    if (armed) begin
      if (hit_a) begin
        s_next.a_seen = 1'b1;
      end
      if (begin_mode) begin
        if (s_reg.phase == RUN_SEEK && trig && !event_mode) begin
          s_next.phase = RUN_FILL;
        end
        if (s_next.cnt == 4'(TRACE_DEPTH)) begin
          stop_run = 1'b1;
        end
      end else if (trig) begin
        stop_run = 1'b1;
      end
    end
    if (stop_run) begin
      s_next.ctl[CTL_ARM] = 1'b0;
      s_next.phase = RUN_IDLE;
      s_next.brk = s_reg.ctl[CTL_BREAK_ENABLE];
      s_next.brk_tag = s_reg.ctl[CTL_TAG];
    end
    // Register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        OFS_CMP_A_HI: if (!s_reg.ctl[CTL_ARM]) s_next.cmp_a[15:8] = w;
        OFS_CMP_A_LO: if (!s_reg.ctl[CTL_ARM]) s_next.cmp_a[7:0] = w;
        OFS_CMP_B_HI: if (!s_reg.ctl[CTL_ARM]) s_next.cmp_b[15:8] = w;
        OFS_CMP_B_LO: if (!s_reg.ctl[CTL_ARM]) s_next.cmp_b[7:0] = w;
        OFS_CONTROL: begin
          s_next.ctl = w;
          s_next.ctl[CTL_UNIT_ENABLE] = w[CTL_UNIT_ENABLE] &&
            (s_reg.ctl[CTL_UNIT_ENABLE] || !mcu_secure);
          s_next.ctl[CTL_ARM] = w[CTL_ARM] &&
            s_next.ctl[CTL_UNIT_ENABLE];
          start = s_next.ctl[CTL_ARM] && !s_reg.ctl[CTL_ARM];
          if (!s_next.ctl[CTL_ARM]) begin
            s_next.phase = RUN_IDLE;
          end
        end
        OFS_HOST_RESET: begin
          if (reg_req.from_host) begin
            s_next.rst_pulse = w[HOST_FORCED_RESET_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (start) begin
      s_next.cnt = 4'h0;
      s_next.a_seen = 1'b0;
      s_next.phase = RUN_SEEK;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign break_req = s_reg.brk;
  assign break_tag = s_reg.brk_tag;
  assign mcu_reset_req = s_reg.rst_pulse;
  assign run_active_flag = armed;
  assign trace_count = s_reg.cnt;
  assign stage_full = !st_in_ready;

endmodule : dbgtc_unit

/* File: dv/dbgtc_cpu_model.sv */
`timescale 1ns/1ps

// ****************************************
// CPU bus model
// ****************************************
module dbgtc_cpu_model
  import dbgtc_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Bus towards the debug unit
  output dbgtc_cpu_bus_t cpu_bus
);
  initial begin
    cpu_bus = '0;
  end

  // Idle cycles show the inverse of the last address and data
  task automatic issue(input logic is_rd, input logic fetch,
                       input logic [15:0] a, input logic [7:0] d,
                       input int gap);
    cpu_bus <= '{valid: 1'b1, is_read: is_rd, addr: a, data: d,
                 op_fetch: fetch, op_exec: fetch};
    @(posedge mclk);
    cpu_bus <= '{valid: 1'b0, is_read: !is_rd, addr: ~a, data: ~d,
                 op_fetch: 1'b0, op_exec: 1'b0};
    @(posedge mclk);
    repeat (gap) @(posedge mclk);
  endtask : issue
endmodule : dbgtc_cpu_model

/* File: dv/dbgtc_unit_checker.sv */
`timescale 1ns/1ps

// ****************************************
// Port checker
// ****************************************
module dbgtc_unit_checker
  import dbgtc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire dbgtc_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // Watched bus and setup
  input wire dbgtc_cpu_bus_t cpu_bus,
  input wire logic [3:0] trig_mode,
  input wire logic trig_begin,
  input wire logic trigger_qualify,
  input wire logic mcu_secure,
  // Results
  input wire logic break_req,
  input wire logic break_tag,
  input wire logic mcu_reset_req,
  input wire logic run_active_flag,
  input wire logic [3:0] trace_count,
  input wire logic stage_full
);
  logic brk_en_reg;
  logic tag_reg;
  logic ctl_wr;
  logic host_hit;
  logic ev_mode;
  assign ctl_wr = reg_req.wr && reg_req.addr == OFS_CONTROL;
  assign host_hit = reg_req.wr && reg_req.from_host &&
    reg_req.addr == OFS_HOST_RESET && reg_req.wdata[HOST_FORCED_RESET_BIT];
  assign ev_mode = trig_mode == TRG_EVENT_B || trig_mode == TRG_A_THEN_EVENT_B;

  // Shadow of the break controls last written
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      brk_en_reg <= 1'b0;
      tag_reg <= 1'b0;
    end else if (ctl_wr) begin
      brk_en_reg <= reg_req.wdata[CTL_BREAK_ENABLE];
      tag_reg <= reg_req.wdata[CTL_TAG];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  property p_host_reset;
    host_hit |=> mcu_reset_req ##1 !mcu_reset_req;
  endproperty
  a_host_reset: assert property (p_host_reset)
    else $error("host reset pulse wrong");
  property p_cpu_reset_ignored;
    mcu_reset_req |-> $past(host_hit);
  endproperty
  a_cpu_reset_ignored: assert property (p_cpu_reset_ignored)
    else $error("reset pulse without host write");
  property p_reset_reg_zero;
    reg_req.rd && reg_req.addr == OFS_HOST_RESET |=> reg_rdata == BYTE_ZERO;
  endproperty
  a_reset_reg_zero: assert property (p_reset_reg_zero)
    else $error("host reset register read not zero");
  property p_event_high_zero;
    reg_req.rd && reg_req.addr == OFS_FIFO_HI && ev_mode
      |=> reg_rdata == 8'h00;
  endproperty
  a_event_high_zero: assert property (p_event_high_zero)
    else $error("fifo high byte not zero in event mode");
  property p_break_single;
    break_req |-> !run_active_flag ##1 !break_req;
  endproperty
  a_break_single: assert property (p_break_single)
    else $error("break pulse or run end wrong");
  property p_break_enabled;
    break_req |-> brk_en_reg && break_tag == tag_reg;
  endproperty
  a_break_enabled: assert property (p_break_enabled)
    else $error("break without enable or wrong type");
  property p_arm_cause;
    $rose(run_active_flag) |-> $past(ctl_wr && reg_req.wdata[CTL_ARM]);
  endproperty
  a_arm_cause: assert property (p_arm_cause)
    else $error("armed without arm write");
  property p_start_clears;
    ctl_wr && reg_req.wdata[7:6] == 2'b11 && !mcu_secure && !run_active_flag
      |=> trace_count == 4'h0;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("count not cleared at start");
  property p_count_max;
    trace_count <= 4'h8;
  endproperty
  a_count_max: assert property (p_count_max)
    else $error("count above eight");
  property p_begin_full_break;
    $rose(trace_count == 4'h8) && brk_en_reg && (trig_begin || ev_mode)
      |-> ##[0:1] break_req;
  endproperty
  a_begin_full_break: assert property (p_begin_full_break)
    else $error("no break when fifo filled");
endmodule : dbgtc_unit_checker

bind dbgtc_unit dbgtc_unit_checker u_checker (.mclk, .sys_rst, .reg_req,
  .reg_rdata, .cpu_bus, .trig_mode, .trig_begin, .trigger_qualify,
  .mcu_secure, .break_req, .break_tag, .mcu_reset_req, .run_active_flag,
  .trace_count, .stage_full);

/* File: dv/tb_dbgtc_unit.sv */
`timescale 1ns/1ps

module tb_dbgtc_unit
  import dbgtc_pkg::*;
;
  logic mclk;
  logic sys_rst = 1'b1;
  dbgtc_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  dbgtc_cpu_bus_t cpu_bus;
  logic [3:0] trig_mode = 4'h0;
  logic trig_begin = 1'b0;
  logic trigger_qualify = 1'b0;
  logic mcu_secure = 1'b0;
  logic break_req, break_tag, mcu_reset_req, run_active_flag, stage_full;
  logic [3:0] trace_count;
  int num_errors = 0;
  int check_count = 0;
  int resets = 0;
  int brk_n = 0;
  logic brk_tag_seen;
  time brk_t;
  time lat [2];
  logic [7:0] cmpv [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
  logic [7:0] d;
  int b0;

  dbgtc_unit u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .cpu_bus(cpu_bus), .trig_mode(trig_mode),
    .trig_begin(trig_begin), .trigger_qualify(trigger_qualify),
    .mcu_secure(mcu_secure), .break_req(break_req), .break_tag(break_tag),
    .mcu_reset_req(mcu_reset_req), .run_active_flag(run_active_flag),
    .trace_count(trace_count), .stage_full(stage_full));
  dbgtc_cpu_model u_cpu (.mclk(mclk), .cpu_bus(cpu_bus));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Pulse monitors, sampled at the edge
  always @(posedge mclk) begin
    if (mcu_reset_req === 1'b1) resets++;
    if (break_req === 1'b1) begin
      brk_n++;
      brk_tag_seen = break_tag;
      brk_t = $time;
    end
  end

  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v,
                        input logic h);
    reg_req <= '{rd: 1'b0, wr: 1'b1, from_host: h, addr: a, wdata: v};
    @(posedge mclk);
    reg_req.wr <= 1'b0;
    @(posedge mclk);
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
    reg_req <= '{rd: 1'b1, wr: 1'b0, from_host: 1'b0, addr: a, wdata: 8'h00};
    @(posedge mclk);
    reg_req.rd <= 1'b0;
    @(posedge mclk);
    v = reg_rdata;
  endtask : reg_rd

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_rd(a, v);
    chk($sformatf("register %h", a), {8'h00, v}, {8'h00, exp});
  endtask : rd_chk

  task automatic wait_break();
    for (int i = 0; i < 20 && brk_n == b0; i++) @(posedge mclk);
  endtask : wait_break

  initial begin
    #(50 * 20000);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) rd_chk(4'(i), 8'h00);
    for (int i = 0; i < 4; i++) begin
      reg_wr(4'(i), cmpv[i], 1'b0);
      rd_chk(4'(i), cmpv[i]);
    end
    $display("test registers done");
    reg_wr(OFS_HOST_RESET, 8'h01, 1'b0);
    repeat (2) @(posedge mclk);
    chk("cpu reset write", 16'(resets), 16'h0000);
    reg_wr(OFS_HOST_RESET, 8'h01, 1'b1);
    repeat (2) @(posedge mclk);
    chk("host reset write", 16'(resets), 16'h0001);
    rd_chk(OFS_HOST_RESET, 8'h00);
    mcu_secure <= 1'b1;
    reg_wr(OFS_CONTROL, 8'hC0, 1'b0);
    rd_chk(OFS_CONTROL, 8'h00);
    mcu_secure <= 1'b0;
    $display("test reset and secure done");
    for (int q = 0; q < 2; q++) begin
      trigger_qualify <= 1'(q);
      reg_wr(OFS_CONTROL, 8'hDC, 1'b0);
      chk("armed", {15'h0000, run_active_flag}, 16'h0001);
      reg_wr(OFS_CMP_A_LO, 8'hFF, 1'b0);
      rd_chk(OFS_CMP_A_LO, 8'h34);
      b0 = brk_n;
      u_cpu.issue(1'b0, 1'b0, 16'h1234, 8'h00, 1);
      repeat (8) @(posedge mclk);
      chk("write break", 16'(brk_n - b0), 16'h0000);
      lat[q] = $time;
      u_cpu.issue(1'b1, 1'b1, 16'h1234, 8'h00, 1);
      wait_break();
      lat[q] = brk_t - lat[q];
      chk("read break", 16'(brk_n - b0), 16'h0001);
      chk("force type", {15'h0000, brk_tag_seen}, 16'h0000);
      rd_chk(OFS_CONTROL, 8'h9C);
    end
    chk("qualify latency", 16'(lat[1]), 16'(lat[0]));
    $display("test end trace done");
    trig_mode <= TRG_EVENT_B;
    trigger_qualify <= 1'b0;
    reg_wr(OFS_CONTROL, 8'hF0, 1'b0);
    b0 = brk_n;
    for (int k = 0; k < 8; k++) begin
      u_cpu.issue(1'b0, 1'b0, 16'h5678, 8'h20 + 8'(k), 1);
      if (k == 3) reg_rd(OFS_FIFO_LO, d);
    end
    wait_break();
    chk("full break", 16'(brk_n - b0), 16'h0001);
    chk("tag type", {15'h0000, brk_tag_seen}, 16'h0001);
    chk("count", {12'h000, trace_count}, 16'h0008);
    chk("run end", {15'h0000, run_active_flag}, 16'h0000);
    reg_wr(OFS_FIFO_LO, 8'hEE, 1'b0);
    reg_wr(OFS_FIFO_HI, 8'hEE, 1'b0);
    for (int k = 0; k < 8; k++) begin
      rd_chk(OFS_FIFO_HI, 8'h00);
      rd_chk(OFS_FIFO_LO, 8'h20 + 8'(k));
    end
    $display("test event trace done");
    trig_mode <= TRG_A_ONLY;
    for (int k = 0; k < 12; k++) begin
      u_cpu.issue(1'b1, 1'b1, 16'h3000 + 16'(k), 8'h00, 1);
      if (k >= 8) rd_chk(OFS_FIFO_HI, 8'h30);
      reg_rd(OFS_FIFO_LO, d);
      if (k >= 8) chk("profile", {8'h00, d}, 16'(k - 8));
    end
    $display("test profiling done");
    trig_begin <= 1'b1;
    reg_wr(OFS_CONTROL, 8'hD0, 1'b0);
    b0 = brk_n;
    u_cpu.issue(1'b1, 1'b1, 16'h1234, 8'h00, 1);
    chk("begin no break", 16'(brk_n - b0), 16'h0000);
    for (int k = 0; k < 8; k++) begin
      u_cpu.issue(1'b1, 1'b1, 16'h4000 + 16'(k), 8'h00, 1);
    end
    wait_break();
    chk("begin break", 16'(brk_n - b0), 16'h0001);
    chk("begin count", {12'h000, trace_count}, 16'h0008);
    chk("stage full", {15'h0000, stage_full}, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      rd_chk(OFS_FIFO_HI, 8'h40);
      rd_chk(OFS_FIFO_LO, 8'(k));
    end
    $display("test begin trace done");
    test_done();
  end
endmodule : tb_dbgtc_unit
